// [hw/acr_rx.sv]
`timescale 1ns/10ps
module acr_rx
   import acr_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic NRST,
   input wire logic RXD,
   input wire logic DOUBLE_SPEED_SELECT,
   input wire logic [DIV_W-1:0] BAUD_DIVISOR_VALUE,
   output logic RX_VALID,
   input wire logic RX_READY,
   output logic [DATA_BITS-1:0] RX_DATA,
   output logic FRAME_ERROR_FLAG,
   output logic RX_STALL
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic line;
      logic [DIV_W-1:0] div;
      acr_state_t st;
      logic [3:0] phase;
      logic [3:0] bitn;
      logic [1:0] votes;
      logic [DATA_BITS-1:0] shift;
      logic push;
      logic [FIFO_W-1:0] word;
   } acr_rx_st_t;
   acr_rx_st_t r_reg, r_next;
   logic tick, in_ready, rx_bit;
   logic [3:0] last_ph, v1, v3;
   logic [FIFO_W-1:0] fifo_out;

   function automatic logic vote_of(input logic [1:0] hi);
      vote_of = hi >= VOTE_MAJ;
   endfunction

   assign tick = r_reg.div == '0;
   assign last_ph = DOUBLE_SPEED_SELECT ? DBL_LAST : NORM_LAST;
   // vote position sets the rate window the link tolerates
   assign v1 = DOUBLE_SPEED_SELECT ? DBL_V1 : NORM_V1;
   assign v3 = DOUBLE_SPEED_SELECT ? DBL_V3 : NORM_V3;
   assign rx_bit = vote_of(r_reg.votes + 2'(r_reg.s2));
   assign RX_STALL = !in_ready;

   always_comb begin
      r_next = r_reg;
      r_next.s1 = RXD;
      r_next.s2 = r_reg.s1;
      r_next.push = 1'b0;
      // divisor sets oversample rate; software owns its accuracy
      r_next.div = tick ? BAUD_DIVISOR_VALUE : r_reg.div - 1'b1;
      if (tick) begin
         r_next.line = r_reg.s2;
         r_next.phase = r_reg.phase + 1'b1;
         if (r_reg.phase >= v1 && r_reg.phase <= v3 && r_reg.st != ACR_IDLE)
            r_next.votes = r_reg.votes + 2'(r_reg.s2);
         case (r_reg.st)
            ACR_IDLE: begin
               // stalls while full; a start taken in a push cycle sees the count before that push, so its frame can still be dropped
               if (r_reg.line && !r_reg.s2 && in_ready) begin
                  r_next.st = ACR_START;
                  r_next.phase = SAMPLE_FIRST;
                  r_next.votes = VOTE_INIT;
               end
            end
            ACR_START: begin
               if (r_reg.phase == v3) begin
                  if (rx_bit) begin
                     r_next.st = ACR_IDLE;
                  end else begin
                     r_next.st = ACR_DATA;
                     r_next.bitn = BIT_FIRST;
                  end
                  r_next.votes = VOTE_INIT;
               end
            end
            ACR_DATA: begin
               if (r_reg.phase == last_ph) r_next.phase = '0;
               if (r_reg.phase == v3) begin
                  r_next.votes = VOTE_INIT;
                  r_next.bitn = r_reg.bitn + 1'b1;
                  if (r_reg.bitn == BIT_STOP) begin
                     r_next.push = 1'b1;
                     r_next.word = {!rx_bit, r_reg.shift};
                     r_next.st = ACR_IDLE;
                     // good stop counts as idle; after a bad one the line must rise first
                     r_next.line = rx_bit;
                  end else begin
                     r_next.shift = {rx_bit, r_reg.shift[DATA_BITS-1:1]};
                  end
               end
            end
            default: r_next.st = ACR_IDLE;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         r_reg <= '0;
         r_reg.s1 <= 1'b1;
         r_reg.s2 <= 1'b1;
         r_reg.line <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   acr_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(SYS_CLK),
      .nrst(NRST),
      .in_valid(r_reg.push),
      .in_ready(in_ready),
      .in_data(r_reg.word),
      .out_valid(RX_VALID),
      .out_ready(RX_READY),
      .out_data(fifo_out)
   );
   assign RX_DATA = fifo_out[DATA_BITS-1:0];
   assign FRAME_ERROR_FLAG = fifo_out[DATA_BITS];

   a_start_reject: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (tick && r_reg.st == ACR_START && r_reg.phase == v3 && rx_bit)
      |=> r_reg.st == ACR_IDLE && !r_reg.push) else $error("noise start accepted");
   a_start_begin: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (tick && r_reg.st == ACR_IDLE && r_reg.line && !r_reg.s2 && in_ready)
      |=> r_reg.st == ACR_START && r_reg.phase == SAMPLE_FIRST) else $error("start not begun");
   a_phase_wrap: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (tick && r_reg.st == ACR_DATA && r_reg.phase == last_ph && !$changed(DOUBLE_SPEED_SELECT))
      |=> r_reg.phase == 4'h0) else $error("bit phase wrong");
   a_stop_flag: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      r_reg.push |-> r_reg.word[DATA_BITS] == !$past(rx_bit)) else $error("stop flag wrong");
   a_push_once: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      r_reg.push |=> !r_reg.push) else $error("double push");
   a_push_idle: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      r_reg.push |-> r_reg.st == ACR_IDLE) else $error("push outside idle");
   a_stall_hold: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (r_reg.st == ACR_IDLE && !in_ready) |=> r_reg.st == ACR_IDLE)
      else $error("start while full");
   a_vote_window: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (tick && r_reg.st != ACR_IDLE && (r_reg.phase < v1 || r_reg.phase > v3))
      |=> r_reg.votes == $past(r_reg.votes)) else $error("vote outside centre");
   c_frame: cover property (@(posedge SYS_CLK) r_reg.push);
   c_noise: cover property (@(posedge SYS_CLK) r_reg.st == ACR_START ##1 r_reg.st == ACR_IDLE);
   c_ferr: cover property (@(posedge SYS_CLK) r_reg.push && r_reg.word[DATA_BITS]);
   c_early: cover property (@(posedge SYS_CLK) r_reg.push ##1 r_reg.st == ACR_START);
endmodule // acr_rx

// [hw/acr_pkg.sv]
package acr_pkg;
   localparam int DIV_W = 12;
   localparam int DATA_BITS = 8;
   localparam int FRAME_BITS = 9;
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_W = 9;
   localparam logic [3:0] NORM_LAST = 4'hf;
   localparam logic [3:0] DBL_LAST = 4'h7;
   localparam logic [3:0] NORM_V1 = 4'h7;
   localparam logic [3:0] NORM_V3 = 4'h9;
   localparam logic [3:0] DBL_V1 = 4'h3;
   localparam logic [3:0] DBL_V3 = 4'h5;
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_STOP = 4'h8;
   localparam logic [1:0] VOTE_INIT = 2'h0;
   localparam logic [1:0] VOTE_MAJ = 2'h2;
   localparam logic [3:0] SAMPLE_FIRST = 4'h1;
   typedef enum logic [1:0] {
      ACR_IDLE = 2'b00,
      ACR_START = 2'b01,
      ACR_DATA = 2'b11
   } acr_state_t;
endpackage

// [hw/acr_fifo.sv]
`timescale 1ns/10ps
module acr_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } acr_fifo_st_t;
   acr_fifo_st_t st_reg, st_next;
   logic push, pop;
   // count one bit wider than the pointers, so all depth slots are usable
   assign in_ready = st_reg.cnt != (AW+1)'(DEPTH);
   assign out_valid = st_reg.cnt != '0;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = st_reg.mem[st_reg.rp];
   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.mem[st_reg.wp] = in_data;
         st_next.wp = st_reg.wp + 1'b1;
      end
      if (pop) st_next.rp = st_reg.rp + 1'b1;
      st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge clk) begin
      if (!nrst) st_reg <= '0;
      else st_reg <= st_next;
   end
endmodule // acr_fifo

// [sim/acr_tx_model.sv]
`timescale 1ns/10ps
module acr_tx_model (
   input wire logic clk,
   output logic line
);
   initial line = 1'b1;
   // times in clocks; callers keep the rate inside the shared error budget
   task automatic send(input logic [7:0] d, input logic stp, input int bt, input int st);
      logic [9:0] f;
      f = {stp, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line = f[i];
         repeat (i == 9 ? st : bt) @(negedge clk);
      end
      // a high stop already idles the line; back-to-back frames need no second write
      if (!stp) line = 1'b1;
   endtask
   task automatic spike(input int n);
      line = 1'b0;
      repeat (n) @(negedge clk);
      line = 1'b1;
   endtask
endmodule // acr_tx_model

// [sim/testbench.sv]
`timescale 1ns/10ps
module testbench;
   import acr_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic rxd;
   logic dbl = 1'b0;
   // tick every clock keeps sample counts exact
   logic [DIV_W-1:0] div = 12'h000;
   logic rdy = 1'b0;
   logic vld, fe, stall;
   logic [DATA_BITS-1:0] dat;
   int num_errors = 0;
   int check_count = 0;
   always #12.5 clk = ~clk;
   acr_tx_model tx (.clk(clk), .line(rxd));
   acr_rx DUT (.SYS_CLK(clk), .NRST(nrst), .RXD(rxd), .DOUBLE_SPEED_SELECT(dbl),
      .BAUD_DIVISOR_VALUE(div), .RX_VALID(vld), .RX_READY(rdy), .RX_DATA(dat),
      .FRAME_ERROR_FLAG(fe), .RX_STALL(stall));
   task automatic check(input string w, input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic get(input logic [7:0] d, input logic f);
      int n;
      n = 0;
      while (vld !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      if (vld !== 1'b1) begin
         num_errors++;
         complete_run();
      end
      check("data", dat, d);
      check("flag", {7'h00, fe}, {7'h00, f});
      rdy = 1'b1;
      @(negedge clk);
      rdy = 1'b0;
      @(negedge clk);
   endtask
   task automatic t_normal();
      tx.send(8'ha5, 1'b1, 16, 16);
      get(8'ha5, 1'b0);
      tx.send(8'h3c, 1'b0, 16, 16);
      get(8'h3c, 1'b1);
      tx.send(8'h81, 1'b1, 16, 10);
      tx.send(8'h7e, 1'b1, 16, 16);
      get(8'h81, 1'b0);
      get(8'h7e, 1'b0);
      $display("normal done");
   endtask
   task automatic t_noise();
      tx.spike(8);
      repeat (200) @(negedge clk);
      check("valid", {7'h00, vld}, 8'h00);
      tx.spike(9);
      get(8'hff, 1'b0);
      $display("noise done");
   endtask
   task automatic t_double();
      dbl = 1'b1;
      tx.spike(4);
      repeat (100) @(negedge clk);
      check("valid", {7'h00, vld}, 8'h00);
      tx.spike(5);
      get(8'hff, 1'b0);
      tx.send(8'h0f, 1'b0, 8, 8);
      get(8'h0f, 1'b1);
      dbl = 1'b0;
      $display("double done");
   endtask
   task automatic t_rate();
      div = 12'h001;
      tx.send(8'h96, 1'b1, 31, 31);
      get(8'h96, 1'b0);
      tx.send(8'h69, 1'b1, 33, 33);
      get(8'h69, 1'b0);
      dbl = 1'b1;
      div = 12'h003;
      tx.send(8'hc3, 1'b1, 31, 33);
      get(8'hc3, 1'b0);
      dbl = 1'b0;
      div = 12'h000;
      $display("rate done");
   endtask
   task automatic t_fill();
      for (int i = 0; i < FIFO_DEPTH; i++)
         tx.send(8'(i), 1'b1, 16, 16);
      check("stall", {7'h00, stall}, 8'h01);
      // sent while full, so it must never appear
      tx.send(8'hee, 1'b1, 16, 16);
      for (int i = 0; i < FIFO_DEPTH; i++)
         get(8'(i), 1'b0);
      check("valid", {7'h00, vld}, 8'h00);
      check("stall", {7'h00, stall}, 8'h00);
      $display("fill done");
   endtask
   initial begin
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      t_normal();
      t_noise();
      t_double();
      t_rate();
      t_fill();
      complete_run();
   end
endmodule // testbench
